// ===== src/rac_pkg.sv
// shared constants and types of the alarm control block
package rac_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_ALARM_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_ALARM_TIME    = 8'h04;
  localparam logic [7:0] ADDR_ALARM_DATE    = 8'h08;
  localparam logic [7:0] ADDR_INT_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_INT_CLEAR     = 8'h10;
  localparam logic [7:0] ADDR_INT_ENABLE    = 8'h14;

  // ==========================================================
  // alarm control field positions
  localparam int POS_ARM   = 15;
  localparam int POS_WRAP  = 14;
  localparam int POS_PIV   = 13;
  localparam int POS_SYNC  = 12;
  localparam int POS_MASK  = 8;
  localparam int POS_COUNT = 0;

  // ==========================================================
  // interrupt status bits
  localparam int INT_W         = 2;
  localparam int INT_ALARM     = 0;
  localparam int INT_DISARMED  = 1;

  // ==========================================================
  // timing: unsafe window before half-second rollover, in rtc clocks
  localparam logic [14:0] UNSAFE_WINDOW = 15'h0020;

  // ==========================================================
  // bus answers, repeat_count wrap reload and reset values
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [7:0]  COUNT_MAX   = 8'hFF;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  // ==========================================================
  // match interval codes
  typedef enum logic [3:0] {
    IVL_HALF_SEC = 4'h0,
    IVL_SECOND   = 4'h1,
    IVL_TEN_SEC  = 4'h2,
    IVL_MINUTE   = 4'h3,
    IVL_TEN_MIN  = 4'h4,
    IVL_HOUR     = 4'h5,
    IVL_DAY      = 4'h6,
    IVL_WEEK     = 4'h7,
    IVL_MONTH    = 4'h8,
    IVL_YEAR     = 4'h9
  } rac_ivl_type;

  // ==========================================================
  // alarm control contents
  typedef struct packed {
    logic       alarm_arm;
    logic       repeat_wrap_enable;
    logic       pulse_initial_level;
    logic [3:0] match_interval_select;
    logic [7:0] repeat_count;
  } rac_ctrl_type;

  // bcd time of day, bit layout of the alarm time register
  typedef struct packed {
    logic [1:0] hour_tens;   // [21:20]
    logic [3:0] hour_ones;   // [19:16]
    logic [2:0] min_tens;    // [14:12]
    logic [3:0] min_ones;    // [11:8]
    logic [2:0] sec_tens;    // [6:4]
    logic [3:0] sec_ones;    // [3:0]
  } rac_time_type;

  // bcd date, bit layout of the alarm date register
  typedef struct packed {
    logic       month_tens;    // [20]
    logic [3:0] month_ones;    // [19:16]
    logic [1:0] day_tens;      // [13:12]
    logic [3:0] day_ones;      // [11:8]
    logic [2:0] weekday_digit; // [2:0]
  } rac_date_type;

  // current time and date from the rtc counters
  typedef struct packed {
    logic         half;
    rac_time_type tod;
    rac_date_type date;
  } rac_now_type;

endpackage

// ===== src/rac_alarm_ctrl.sv
// alarm control unit of the rtc with axi4-lite register access
//
// Summary of operation
// - alarms are matched and events produced only while alarm_arm is set
// - with wrap enabled, repeat_count wraps 0x00 to 0xFF, repeating forever
// - with wrap disabled, repeat_count stops decrementing at zero
// - while disarmed, pulse_initial_level is writable and sets the pulse start level
// - while armed, pulse_initial_level ignores writes and reads the live pulse
// - alarm_read_unsafe is set when a half-second rollover may disturb reads
// - alarm_read_unsafe clears only when rollover is over 32 rtc clocks away
// - match_interval_select picks the alarm period, half-second up to yearly
// - yearly alarm set on February 29 fires only once in four years
// - event at count zero with wrap off clears alarm_arm in hardware
// - alarm control resets only on power-on reset, not other resets
// - alarm date holds valid bcd digits for month, day and weekday
//
// The address map and register access over AXI4-Lite were decided locally.
module rac_alarm_ctrl (
  // clock and resets
  input  wire logic                  CLK_IN,
  input  wire logic                  RST_IN,
  input  wire logic                  POR_IN,
  // rtc core
  input  wire logic                  HALF_SEC_TICK_IN,
  input  wire logic [14:0]           PRESCALE_LEFT_IN,
  input  wire rac_pkg::rac_now_type  NOW_IN,
  // axi4-lite write address and data
  input  wire logic                  S_AXI_AWVALID_IN,
  output logic                       S_AXI_AWREADY_OUT,
  input  wire logic [7:0]            S_AXI_AWADDR_IN,
  input  wire logic                  S_AXI_WVALID_IN,
  output logic                       S_AXI_WREADY_OUT,
  input  wire logic [31:0]           S_AXI_WDATA_IN,
  input  wire logic [3:0]            S_AXI_WSTRB_IN,
  // axi4-lite write response
  output logic                       S_AXI_BVALID_OUT,
  input  wire logic                  S_AXI_BREADY_IN,
  output logic [1:0]                 S_AXI_BRESP_OUT,
  // axi4-lite read
  input  wire logic                  S_AXI_ARVALID_IN,
  output logic                       S_AXI_ARREADY_OUT,
  input  wire logic [7:0]            S_AXI_ARADDR_IN,
  output logic                       S_AXI_RVALID_OUT,
  input  wire logic                  S_AXI_RREADY_IN,
  output logic [31:0]                S_AXI_RDATA_OUT,
  output logic [1:0]                 S_AXI_RRESP_OUT,
  // alarm outputs
  output logic                       ALARM_PULSE_OUT,
  output logic                       IRQ_OUT
);
  import rac_pkg::*;

  // ==========================================================
  // state of the whole block
  typedef struct packed {
    rac_ctrl_type     ctrl;
    rac_time_type     atime;
    rac_date_type     adate;
    logic             pulse;
    logic             unsafe;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_en;
    logic             irq;
    logic             awready;
    logic             aw_held;
    logic [7:0]       awaddr;
    logic             wready;
    logic             w_held;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } rac_state_type;

  rac_state_type st_reg;
  rac_state_type st_next;

  // ==========================================================
  // helper functions

  // merge a write word into an old word by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

  // alarm date word layout
  function automatic logic [31:0] date_word(input rac_date_type d);
    return {11'h000, d.month_tens, d.month_ones, 2'h0, d.day_tens, d.day_ones,
            5'h00, d.weekday_digit};
  endfunction

  // alarm time word layout
  function automatic logic [31:0] time_word(input rac_time_type t);
    return {10'h000, t.hour_tens, t.hour_ones, 1'b0, t.min_tens, t.min_ones,
            1'b0, t.sec_tens, t.sec_ones};
  endfunction

  // compare the fields that the selected interval covers
  function automatic logic interval_match(input logic [3:0]   ivl,
                                          input rac_now_type  now,
                                          input rac_time_type at,
                                          input rac_date_type ad);
    logic h0, s1, s10, m1, m10, hr, wd, dy, mo;
    h0  = !now.half;
    s1  = now.tod.sec_ones == at.sec_ones;
    s10 = now.tod.sec_tens == at.sec_tens;
    m1  = now.tod.min_ones == at.min_ones;
    m10 = now.tod.min_tens == at.min_tens;
    hr  = now.tod.hour_tens == at.hour_tens && now.tod.hour_ones == at.hour_ones;
    wd  = now.date.weekday_digit == ad.weekday_digit;
    dy  = now.date.day_tens == ad.day_tens && now.date.day_ones == ad.day_ones;
    mo  = now.date.month_tens == ad.month_tens && now.date.month_ones == ad.month_ones;
    unique case (ivl)
      IVL_HALF_SEC: return 1'b1;
      IVL_SECOND:   return h0;
      IVL_TEN_SEC:  return h0 && s1;
      IVL_MINUTE:   return h0 && s1 && s10;
      IVL_TEN_MIN:  return h0 && s1 && s10 && m1;
      IVL_HOUR:     return h0 && s1 && s10 && m1 && m10;
      IVL_DAY:      return h0 && s1 && s10 && m1 && m10 && hr;
      IVL_WEEK:     return h0 && s1 && s10 && m1 && m10 && hr && wd;
      IVL_MONTH:    return h0 && s1 && s10 && m1 && m10 && hr && dy;
      // feb 29 only occurs in leap years, so it matches every fourth year
      IVL_YEAR:     return h0 && s1 && s10 && m1 && m10 && hr && dy && mo;
      default:      return 1'b0; // reserved codes never match
    endcase
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    logic         aw_go;
    logic         w_go;
    logic         do_wr;
    logic         ar_go;
    logic         hit;
    logic [31:0]  wv;
    rac_date_type dnew;
    aw_go   = 1'b0;
    w_go    = 1'b0;
    do_wr   = 1'b0;
    ar_go   = 1'b0;
    hit     = 1'b0;
    wv      = WORD_ZERO;
    dnew    = '0;
    st_next = st_reg;

    // capture write address and data in either order
    aw_go = S_AXI_AWVALID_IN && st_reg.awready;
    w_go  = S_AXI_WVALID_IN && st_reg.wready;
    if (aw_go) begin
      st_next.aw_held = 1'b1;
      st_next.awaddr  = S_AXI_AWADDR_IN;
    end
    if (w_go) begin
      st_next.w_held = 1'b1;
      st_next.wdata  = S_AXI_WDATA_IN;
      st_next.wstrb  = S_AXI_WSTRB_IN;
    end

    // write response handshake
    if (st_reg.bvalid && S_AXI_BREADY_IN) begin
      st_next.bvalid = 1'b0;
    end

    // perform a held write once both halves are in and no response is pending
    do_wr = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    if (do_wr) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = RESP_OKAY;
      unique case (st_reg.awaddr)
        ADDR_ALARM_CONTROL: begin
          wv = merge({16'h0000, st_reg.ctrl.alarm_arm, st_reg.ctrl.repeat_wrap_enable,
                      st_reg.ctrl.pulse_initial_level, 1'b0,
                      st_reg.ctrl.match_interval_select, st_reg.ctrl.repeat_count},
                     st_reg.wdata, st_reg.wstrb);
          st_next.ctrl.alarm_arm             = wv[POS_ARM];
          st_next.ctrl.repeat_wrap_enable    = wv[POS_WRAP];
          st_next.ctrl.match_interval_select = wv[POS_MASK +: 4];
          st_next.ctrl.repeat_count          = wv[POS_COUNT +: 8];
          if (!st_reg.ctrl.alarm_arm) begin
            st_next.ctrl.pulse_initial_level = wv[POS_PIV];
            st_next.pulse                    = wv[POS_PIV];
          end
        end
        ADDR_ALARM_TIME: begin
          wv = merge(time_word(st_reg.atime), st_reg.wdata, st_reg.wstrb);
          st_next.atime = {wv[21:16], wv[14:8], wv[6:0]};
        end
        ADDR_ALARM_DATE: begin
          wv   = merge(date_word(st_reg.adate), st_reg.wdata, st_reg.wstrb);
          dnew = {wv[20:16], wv[13:8], wv[2:0]};
          // out-of-range bcd digits keep their old value
          if (dnew.month_ones <= 4'h9) begin
            st_next.adate.month_tens = dnew.month_tens;
            st_next.adate.month_ones = dnew.month_ones;
          end
          if (dnew.day_ones <= 4'h9) begin
            st_next.adate.day_tens = dnew.day_tens;
            st_next.adate.day_ones = dnew.day_ones;
          end
          if (dnew.weekday_digit <= 3'h6) begin
            st_next.adate.weekday_digit = dnew.weekday_digit;
          end
        end
        ADDR_INT_STATUS: begin
          st_next.bresp = RESP_OKAY; // read-only, write ignored
        end
        ADDR_INT_CLEAR: begin
          st_next.int_stat = st_reg.int_stat & ~st_reg.wdata[INT_W-1:0];
        end
        ADDR_INT_ENABLE: begin
          if (st_reg.wstrb[0]) begin
            st_next.int_en = st_reg.wdata[INT_W-1:0];
          end
        end
        default: begin
          st_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    st_next.awready = !st_next.aw_held;
    st_next.wready  = !st_next.w_held;

    // read channel: one read under way at a time
    if (st_reg.rvalid && S_AXI_RREADY_IN) begin
      st_next.rvalid = 1'b0;
    end
    ar_go = S_AXI_ARVALID_IN && st_reg.arready;
    if (ar_go) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      unique case (S_AXI_ARADDR_IN)
        ADDR_ALARM_CONTROL: begin
          st_next.rdata = {16'h0000, st_reg.ctrl.alarm_arm, st_reg.ctrl.repeat_wrap_enable,
                           st_reg.ctrl.alarm_arm ? st_reg.pulse
                                                 : st_reg.ctrl.pulse_initial_level,
                           st_reg.unsafe, st_reg.ctrl.match_interval_select,
                           st_reg.ctrl.repeat_count};
        end
        ADDR_ALARM_TIME: st_next.rdata = time_word(st_reg.atime);
        ADDR_ALARM_DATE: st_next.rdata = date_word(st_reg.adate);
        ADDR_INT_STATUS: st_next.rdata = {30'h0000_0000, st_reg.int_stat};
        ADDR_INT_CLEAR:  st_next.rdata = WORD_ZERO;
        ADDR_INT_ENABLE: st_next.rdata = {30'h0000_0000, st_reg.int_en};
        default: begin
          st_next.rdata = WORD_ZERO;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    st_next.arready = !st_next.rvalid;

    // read-safety flag from the prescaler distance to rollover
    st_next.unsafe = PRESCALE_LEFT_IN <= UNSAFE_WINDOW;

    // alarm event on a half-second tick, applied after any register write
    hit = HALF_SEC_TICK_IN && st_reg.ctrl.alarm_arm &&
          interval_match(st_reg.ctrl.match_interval_select, NOW_IN,
                         st_reg.atime, st_reg.adate);
    if (hit) begin
      st_next.pulse               = !st_reg.pulse;
      st_next.int_stat[INT_ALARM] = 1'b1;
      if (st_reg.ctrl.repeat_count != 8'h00) begin
        st_next.ctrl.repeat_count = st_reg.ctrl.repeat_count - 8'h01;
      end else if (st_reg.ctrl.repeat_wrap_enable) begin
        st_next.ctrl.repeat_count = COUNT_MAX;
      end else begin
        // count held at zero, alarm disarms itself
        st_next.ctrl.repeat_count      = 8'h00;
        st_next.ctrl.alarm_arm         = 1'b0;
        st_next.int_stat[INT_DISARMED] = 1'b1;
      end
    end

    // interrupt output, one cycle behind status
    st_next.irq = |(st_reg.int_stat & st_reg.int_en);

    // power-on reset alone restores the alarm settings
    if (POR_IN) begin
      st_next.ctrl  = '0;
      st_next.atime = '0;
      st_next.adate = '0;
      st_next.pulse = 1'b0;
    end

    // bus and interrupt reset
    if (RST_IN || POR_IN) begin
      st_next.int_stat = '0;
      st_next.int_en   = '0;
      st_next.irq      = 1'b0;
      st_next.aw_held  = 1'b0;
      st_next.w_held   = 1'b0;
      st_next.awaddr   = 8'h00;
      st_next.wdata    = WORD_ZERO;
      st_next.wstrb    = 4'h0;
      st_next.awready  = 1'b1;
      st_next.wready   = 1'b1;
      st_next.bvalid   = 1'b0;
      st_next.bresp    = RESP_OKAY;
      st_next.arready  = 1'b1;
      st_next.rvalid   = 1'b0;
      st_next.rdata    = WORD_ZERO;
      st_next.rresp    = RESP_OKAY;
      st_next.unsafe   = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK_IN) begin
    st_reg <= st_next;
  end

  // outputs straight from the state flops
  assign S_AXI_AWREADY_OUT = st_reg.awready;
  assign S_AXI_WREADY_OUT  = st_reg.wready;
  assign S_AXI_BVALID_OUT  = st_reg.bvalid;
  assign S_AXI_BRESP_OUT   = st_reg.bresp;
  assign S_AXI_ARREADY_OUT = st_reg.arready;
  assign S_AXI_RVALID_OUT  = st_reg.rvalid;
  assign S_AXI_RDATA_OUT   = st_reg.rdata;
  assign S_AXI_RRESP_OUT   = st_reg.rresp;
  assign ALARM_PULSE_OUT   = st_reg.pulse;
  assign IRQ_OUT           = st_reg.irq;

endmodule

// ===== dv/rac_alarm_ctrl_checker.sv
// port-level assertions for the alarm control block
module rac_alarm_ctrl_checker (
  // clock and resets
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        POR_IN,
  // rtc core
  input wire logic        HALF_SEC_TICK_IN,
  input wire logic [14:0] PRESCALE_LEFT_IN,
  // bus
  input wire logic        S_AXI_AWVALID_IN,
  input wire logic        S_AXI_AWREADY_OUT,
  input wire logic        S_AXI_WVALID_IN,
  input wire logic        S_AXI_WREADY_OUT,
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic        S_AXI_BREADY_IN,
  input wire logic [1:0]  S_AXI_BRESP_OUT,
  input wire logic        S_AXI_ARVALID_IN,
  input wire logic        S_AXI_ARREADY_OUT,
  input wire logic [7:0]  S_AXI_ARADDR_IN,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        S_AXI_RREADY_IN,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic [1:0]  S_AXI_RRESP_OUT,
  // alarm output
  input wire logic        ALARM_PULSE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  import rac_pkg::*;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN || POR_IN);
  // ==========================================================
  // alarm and read-safety relations
  chk_pulse_cause: assert property (
    $changed(ALARM_PULSE_OUT) |-> $past(HALF_SEC_TICK_IN) || !$past(S_AXI_WREADY_OUT))
    else $error("alarm pulse moved without tick or write");
  chk_sync_safe: assert property (
    $rose(S_AXI_RVALID_OUT) && $past(S_AXI_ARADDR_IN) == ADDR_ALARM_CONTROL
    && $past(PRESCALE_LEFT_IN) > UNSAFE_WINDOW && $past(PRESCALE_LEFT_IN, 2) > UNSAFE_WINDOW
    |-> !S_AXI_RDATA_OUT[POS_SYNC])
    else $error("read flagged unsafe far from rollover");
  chk_sync_unsafe: assert property (
    $rose(S_AXI_RVALID_OUT) && $past(S_AXI_ARADDR_IN) == ADDR_ALARM_CONTROL
    && $past(PRESCALE_LEFT_IN) <= UNSAFE_WINDOW && $past(PRESCALE_LEFT_IN, 2) <= UNSAFE_WINDOW
    |-> S_AXI_RDATA_OUT[POS_SYNC])
    else $error("read not flagged unsafe near rollover");
  // ==========================================================
  // bus handshake relations
  chk_rd_latency: assert property (
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
    else $error("read answer late");
  chk_wr_latency: assert property (
    S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN
    && S_AXI_WREADY_OUT |-> ##2 S_AXI_BVALID_OUT)
    else $error("write answer late");
  chk_r_hold: assert property (
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("read answer dropped");
  chk_b_hold: assert property (
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
    else $error("write answer dropped");
  chk_rd_unmapped: assert property (
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && S_AXI_ARADDR_IN > ADDR_INT_ENABLE
    |=> S_AXI_RRESP_OUT == RESP_SLVERR && S_AXI_RDATA_OUT == WORD_ZERO)
    else $error("unmapped read not refused");
endmodule

bind rac_alarm_ctrl rac_alarm_ctrl_checker u_chk (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .POR_IN(POR_IN),
  .HALF_SEC_TICK_IN(HALF_SEC_TICK_IN), .PRESCALE_LEFT_IN(PRESCALE_LEFT_IN),
  .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN), .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
  .S_AXI_WVALID_IN(S_AXI_WVALID_IN), .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
  .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_BREADY_IN(S_AXI_BREADY_IN),
  .S_AXI_BRESP_OUT(S_AXI_BRESP_OUT), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
  .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_ARADDR_IN(S_AXI_ARADDR_IN),
  .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
  .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT), .S_AXI_RRESP_OUT(S_AXI_RRESP_OUT),
  .ALARM_PULSE_OUT(ALARM_PULSE_OUT));

// ===== dv/rac_alarm_ctrl_bench.sv
// register-level testbench of the alarm control block
module rac_alarm_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rac_pkg::*;
  logic clk = 0, rst = 1, por = 1, tick = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic awr, wr, bv, arr, rv, pulse, irq;
  logic [14:0] presc = 15'h0010;
  rac_now_type now = '0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdat, rd;
  logic [1:0] br, rr, bs, rs;
  int num_errors = 0, n_tests = 0, cycles = 0;
  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  rac_alarm_ctrl DUT (.CLK_IN(clk), .RST_IN(rst), .POR_IN(por), .HALF_SEC_TICK_IN(tick),
    .PRESCALE_LEFT_IN(presc), .NOW_IN(now), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_AWADDR_IN(awa), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr), .S_AXI_WDATA_IN(wd),
    .S_AXI_WSTRB_IN(4'hF), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry), .S_AXI_BRESP_OUT(br),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rry), .S_AXI_RDATA_OUT(rdat),
    .S_AXI_RRESP_OUT(rr), .ALARM_PULSE_OUT(pulse), .IRQ_OUT(irq));
  // ==========================================================
  // helpers
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      #1;
      ta = awv && awr;
      tw = wv && wr;
      tb = bv && bry;
      if (tb) bs = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) bry <= 1'b0;
    end
  endtask
  // each read finishes in two cycles, far inside the read-safety window
  task automatic bus_rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      #1;
      ta = arv && arr;
      tr = rv && rry;
      if (tr) rd = rdat;
      if (tr) rs = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) rry <= 1'b0;
    end
  endtask
  task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e, logic [31:0] m = 32'hFFFF_FFFF);
    bus_rd(a);
    check(n, rd & m, e & m);
  endtask
  function automatic logic [31:0] ctl(logic a, logic w, logic p, logic [3:0] m, logic [7:0] c);
    return {16'h0000, a, w, p, 1'b0, m, c};
  endfunction
  // one half-second tick, then let the event land
  task automatic fire;
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    wt(3);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    por <= 1'b0;
    rst <= 1'b0;
    rd_chk("ctrl reset", ADDR_ALARM_CONTROL, 32'h0000_1000);
    presc <= 15'h0021;
    rd_chk("ctrl safe", ADDR_ALARM_CONTROL, 32'h0000_0000);
    presc <= 15'h0020;
    rd_chk("ctrl unsafe", ADDR_ALARM_CONTROL, 32'h0000_1000);
    rd_chk("count reread", ADDR_ALARM_CONTROL, 32'h0000_1000);
    presc <= 15'h0100;
    bus_rd(8'h40);
    check("unmapped rresp", 32'(rs), 32'(RESP_SLVERR));
    bus_wr(8'h40, 32'h0000_0001);
    check("unmapped bresp", 32'(bs), 32'(RESP_SLVERR));
    $display("reset and safety test done");
    bus_wr(ADDR_ALARM_CONTROL, ctl(0, 0, 1, 4'h0, 8'h00));
    wt(2);
    check("pulse start high", 32'(pulse), 32'h1);
    rd_chk("piv read", ADDR_ALARM_CONTROL, ctl(0, 0, 1, 4'h0, 8'h00));
    bus_wr(ADDR_ALARM_CONTROL, ctl(0, 0, 0, 4'h0, 8'h00));
    wt(2);
    check("pulse start low", 32'(pulse), 32'h0);
    $display("initial level test done");
    bus_wr(ADDR_INT_ENABLE, 32'h0000_0003);
    bus_wr(ADDR_ALARM_CONTROL, ctl(1, 0, 0, IVL_HALF_SEC, 8'h01));
    fire;
    check("pulse toggle", 32'(pulse), 32'h1);
    rd_chk("count one", ADDR_ALARM_CONTROL, ctl(1, 0, 1, 4'h0, 8'h00));
    fire;
    check("pulse toggle back", 32'(pulse), 32'h0);
    rd_chk("hw disarm", ADDR_ALARM_CONTROL, 32'h0000_0000, 32'hFFFF_DFFF);
    rd_chk("status", ADDR_INT_STATUS, 32'h0000_0003);
    check("irq set", 32'(irq), 32'h1);
    bus_wr(ADDR_INT_ENABLE, 32'h0000_0000);
    wt(2);
    check("irq masked", 32'(irq), 32'h0);
    bus_wr(ADDR_INT_ENABLE, 32'h0000_0003);
    bus_wr(ADDR_INT_CLEAR, 32'h0000_0003);
    wt(2);
    check("irq cleared", 32'(irq), 32'h0);
    fire;
    check("disarmed pulse", 32'(pulse), 32'h0);
    rd_chk("disarmed status", ADDR_INT_STATUS, 32'h0000_0000);
    $display("event and interrupt test done");
    bus_wr(ADDR_ALARM_CONTROL, ctl(1, 1, 0, IVL_HALF_SEC, 8'h00));
    fire;
    rd_chk("wrap", ADDR_ALARM_CONTROL, ctl(1, 1, 1, 4'h0, 8'hFF));
    bus_wr(ADDR_ALARM_CONTROL, ctl(1, 1, 0, IVL_HALF_SEC, 8'hFF));
    wt(2);
    check("armed piv write", 32'(pulse), 32'h1);
    rd_chk("armed piv read", ADDR_ALARM_CONTROL, ctl(1, 1, 1, 4'h0, 8'hFF));
    $display("wrap test done");
    // every legal interval code; reserved codes are never programmed
    for (int i = 0; i < 10; i++) begin
      bus_wr(ADDR_ALARM_CONTROL, ctl(1, 1, 0, 4'(i), 8'h10));
      fire;
      rd_chk("interval", ADDR_ALARM_CONTROL, ctl(1, 1, 0, 4'(i), 8'h0F), 32'hFFFF_DFFF);
    end
    now.tod.sec_ones <= 4'h1;
    bus_wr(ADDR_ALARM_CONTROL, ctl(1, 1, 0, IVL_MINUTE, 8'h10));
    fire;
    rd_chk("field mismatch", ADDR_ALARM_CONTROL, ctl(1, 1, 0, 4'h3, 8'h10), 32'hFFFF_DFFF);
    bus_wr(ADDR_ALARM_CONTROL, ctl(1, 1, 0, IVL_HALF_SEC, 8'h10));
    fire;
    rd_chk("half ignores", ADDR_ALARM_CONTROL, ctl(1, 1, 0, 4'h0, 8'h0F), 32'hFFFF_DFFF);
    now <= '0;
    $display("interval test done");
    bus_wr(ADDR_ALARM_CONTROL, ctl(0, 0, 0, IVL_HOUR, 8'h33));
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd_chk("keep on reset", ADDR_ALARM_CONTROL, ctl(0, 0, 0, 4'h5, 8'h33));
    bus_wr(ADDR_ALARM_DATE, 32'h0011_2305);
    rd_chk("date", ADDR_ALARM_DATE, 32'h0011_2305);
    bus_wr(ADDR_ALARM_DATE, 32'h001A_1204);
    rd_chk("bad month", ADDR_ALARM_DATE, 32'h0011_1204);
    $display("retention and date test done");
    report_and_stop();
  end
endmodule
